// File: hdl/output_fallback_defines.vh
/*
 * Constants for the output fallback controller: channel count, widths,
 * fallback modes and reset values. Assumes a 250 MHz core clock.
 */
// How it works
// - Fallback drives each channel's predefined or held value
// - Fieldbus master link loss triggers fallback
// - Missing gateway or module heartbeat triggers fallback
// - Run-to-stop or reset command triggers fallback
// - Missing mandatory module triggers fallback
// - A failed module skips its own fallback
// - Gateway heartbeat suppressed under any trigger
// - Modules fall back on heartbeat timeout
// - Only reflex channels run without heartbeat
// - Reflex source module lost forces fallback
// - Reflex channels fall back on fieldbus loss, one exception
// - Mode and value held per channel
// - Settings apply only during interruption, kept nonvolatile
// - Hold mode keeps last assigned value
// - Predefined mode and zero are defaults
// - Discrete off/on, analog zero or in-range
// - Auto-configured island uses defaults only
// - Heartbeats exchanged periodically while healthy
`ifndef OUTPUT_FALLBACK_DEFINES_VH
`define OUTPUT_FALLBACK_DEFINES_VH

`define NUM_MODULES 4
`define NUM_CHANNELS 2
`define DATA_WIDTH 16
`define MODE_HOLD 1'b1
`define MODE_PREDEF 1'b0
`define RST_MODE 1'b0
`define RST_VALUE 16'h0000
`define ANALOG_MAX 16'h7FFF
`define HB_PERIOD_NS 10000
`define HB_PERIOD_CYC ((`HB_PERIOD_NS) / 4)
`define HB_TIMEOUT_NS 100000
`define HB_TIMEOUT_CYC ((`HB_TIMEOUT_NS) / 4)
`define CNT_WIDTH 16

`endif

// File: hdl/heartbeat_watch.v
/*
 * Heartbeat watchdog for one I/O module: restarts on each heartbeat and
 * raises a sticky timeout. Assumes heartbeat pulses are synchronous.
 */
`timescale 1ns/1ps
`include "output_fallback_defines.vh"
module heartbeat_watch (
    input wire core_clk_in,
    input wire rstn_in,
    input wire ce_in,
    input wire recover_in,
    input wire hb_in,
    input wire [`CNT_WIDTH-1:0] timeout_in,
    output reg expired_out
);
    reg [`CNT_WIDTH-1:0] cnt_r;

    always @(posedge core_clk_in) begin
        if (!rstn_in) begin
            cnt_r <= {`CNT_WIDTH{1'b0}};
            expired_out <= 1'b0;
        end else if (ce_in) begin
            if (hb_in) begin
                cnt_r <= {`CNT_WIDTH{1'b0}};
            end else if (cnt_r < timeout_in) begin
                cnt_r <= cnt_r + 1'b1;
            end
            // Expiry wins over a same-cycle recover so no timeout is lost
            if (!hb_in && cnt_r + 1'b1 >= timeout_in) begin
                expired_out <= 1'b1;
            end else if (recover_in) begin
                expired_out <= 1'b0;
            end
        end
    end
endmodule // heartbeat_watch

// File: hdl/channel_output.v
/*
 * One output channel: selects commanded data, held value or predefined
 * fallback value. Assumes the fallback decision comes from the controller.
 */
`timescale 1ns/1ps
`include "output_fallback_defines.vh"
module channel_output (
    input wire core_clk_in,
    input wire rstn_in,
    input wire ce_in,
    input wire fallback_in,
    input wire mode_in,
    input wire [`DATA_WIDTH-1:0] value_in,
    input wire [`DATA_WIDTH-1:0] cmd_in,
    output reg [`DATA_WIDTH-1:0] out_out
);
    reg [`DATA_WIDTH-1:0] last_r;

    always @(posedge core_clk_in) begin
        if (!rstn_in) begin
            last_r <= `RST_VALUE;
            out_out <= `RST_VALUE;
        end else if (ce_in) begin
            if (!fallback_in) begin
                last_r <= cmd_in;
                out_out <= cmd_in;
            end else if (mode_in == `MODE_HOLD) begin
                out_out <= last_r;
            end else begin
                out_out <= value_in;
            end
        end
    end
endmodule // channel_output

// File: hdl/output_fallback_control.v
/*
 * Output fallback controller for an I/O island: gateway heartbeat source,
 * per-module watchdogs, fallback triggers and per-channel output selection.
 * Assumes all inputs synchronous to core_clk_in; configuration comes from
 * nonvolatile storage outside and is presented here as plain ports.
 */
`timescale 1ns/1ps
`include "output_fallback_defines.vh"
module output_fallback_control #(
    parameter HB_PERIOD = `HB_PERIOD_CYC,
    parameter HB_TIMEOUT = `HB_TIMEOUT_CYC
) (
    input wire core_clk_in,
    input wire rstn_in,
    input wire ce_in,
    input wire fieldbus_ok_in,
    input wire run_cmd_in,
    input wire recover_in,
    input wire auto_config_in,
    input wire [`NUM_MODULES-1:0] module_hb_in,
    input wire [`NUM_MODULES-1:0] module_present_in,
    input wire [`NUM_MODULES-1:0] module_mandatory_in,
    input wire [`NUM_MODULES-1:0] module_operating_in,
    input wire [`NUM_MODULES*`NUM_CHANNELS-1:0] reflex_ch_in,
    input wire [`NUM_MODULES*`NUM_CHANNELS-1:0] reflex_src_ok_in,
    input wire [`NUM_MODULES*`NUM_CHANNELS-1:0] analog_ch_in,
    input wire [`NUM_MODULES-1:0] two_ch_digital_in,
    input wire [`NUM_MODULES*`NUM_CHANNELS-1:0] cfg_mode_in,
    input wire [`NUM_MODULES*`NUM_CHANNELS*`DATA_WIDTH-1:0] cfg_value_in,
    input wire [`NUM_MODULES*`NUM_CHANNELS*`DATA_WIDTH-1:0] cmd_data_in,
    input wire [`NUM_MODULES*`NUM_CHANNELS*`DATA_WIDTH-1:0] reflex_data_in,
    output reg gateway_hb_out,
    output reg island_fallback_out,
    output reg [`NUM_MODULES-1:0] module_timeout_out,
    output reg [`NUM_MODULES*`NUM_CHANNELS-1:0] ch_fallback_out,
    output wire [`NUM_MODULES*`NUM_CHANNELS*`DATA_WIDTH-1:0] ch_data_out
);
    localparam NCH = `NUM_MODULES * `NUM_CHANNELS;
    localparam [`CNT_WIDTH-1:0] HB_PER_W = HB_PERIOD[`CNT_WIDTH-1:0];
    localparam [`CNT_WIDTH-1:0] HB_TO_W = HB_TIMEOUT[`CNT_WIDTH-1:0];
    localparam ST_RUN = 2'b00;
    localparam ST_FALLBACK = 2'b01;
    localparam ST_WAIT = 2'b10;

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg run_prev_r;
    reg [`CNT_WIDTH-1:0] hb_cnt_r;
    reg [NCH-1:0] ch_fb_nxt;
    reg [NCH*`DATA_WIDTH-1:0] sel_data;
    wire [`NUM_MODULES-1:0] expired;
    wire [NCH*`DATA_WIDTH-1:0] eff_value;
    wire [NCH-1:0] eff_mode;
    wire [NCH-1:0] ch_mux_fb;
    wire stop_cmd;
    wire mandatory_missing;
    wire island_hb_lost;
    wire trigger;

    assign stop_cmd = run_prev_r && !run_cmd_in;
    assign mandatory_missing = |(module_mandatory_in &
        ~(module_present_in & module_operating_in));
    assign island_hb_lost = |(expired & module_present_in & module_operating_in);
    assign trigger = !fieldbus_ok_in || stop_cmd || !run_cmd_in ||
        mandatory_missing || island_hb_lost;

    // Fallback stays until the gateway re-establishes operation
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (trigger) begin
                    state_nxt = ST_FALLBACK;
                end
            end
            ST_FALLBACK: begin
                if (recover_in && !trigger) begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (trigger) begin
                    state_nxt = ST_FALLBACK;
                end else begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_FALLBACK;
            end
        endcase
    end

    always @(posedge core_clk_in) begin
        if (!rstn_in) begin
            state_r <= ST_FALLBACK;
            run_prev_r <= 1'b0;
            hb_cnt_r <= {`CNT_WIDTH{1'b0}};
            gateway_hb_out <= 1'b0;
            island_fallback_out <= 1'b1;
            module_timeout_out <= {`NUM_MODULES{1'b0}};
            ch_fallback_out <= {NCH{1'b1}};
        end else if (ce_in) begin
            state_r <= state_nxt;
            run_prev_r <= run_cmd_in;
            island_fallback_out <= (state_nxt != ST_RUN);
            module_timeout_out <= expired;
            ch_fallback_out <= ch_fb_nxt;
            // Heartbeat only while running; silence makes modules fall back
            if (state_nxt != ST_RUN) begin
                hb_cnt_r <= {`CNT_WIDTH{1'b0}};
                gateway_hb_out <= 1'b0;
            end else if (hb_cnt_r + 1'b1 >= HB_PER_W) begin
                hb_cnt_r <= {`CNT_WIDTH{1'b0}};
                gateway_hb_out <= 1'b1;
            end else begin
                hb_cnt_r <= hb_cnt_r + 1'b1;
                gateway_hb_out <= 1'b0;
            end
        end
    end

    genvar m;
    generate
        for (m = 0; m < `NUM_MODULES; m = m + 1) begin : g_mod
            heartbeat_watch u_watch (
                .core_clk_in(core_clk_in),
                .rstn_in(rstn_in),
                .ce_in(ce_in),
                .recover_in(recover_in),
                .hb_in(module_hb_in[m]),
                .timeout_in(HB_TO_W),
                .expired_out(expired[m])
            );
        end
    endgenerate

    // Per-channel fallback decision
    integer c;
    integer mi;
    always @* begin
        ch_fb_nxt = {NCH{1'b0}};
        mi = 0;
        for (c = 0; c < NCH; c = c + 1) begin
            mi = c / `NUM_CHANNELS;
            if (!module_operating_in[mi] || !module_present_in[mi]) begin
                ch_fb_nxt[c] = 1'b0;
            end else if (reflex_ch_in[c]) begin
                if (!reflex_src_ok_in[c]) begin
                    ch_fb_nxt[c] = 1'b1;
                end else if (!fieldbus_ok_in) begin
                    // Two-channel digital module, both reflex: keeps solving
                    ch_fb_nxt[c] = !(two_ch_digital_in[mi] &&
                        reflex_ch_in[mi*`NUM_CHANNELS] &&
                        reflex_ch_in[mi*`NUM_CHANNELS+1]);
                end else begin
                    ch_fb_nxt[c] = 1'b0;
                end
            end else begin
                ch_fb_nxt[c] = (state_nxt != ST_RUN) || expired[mi];
            end
        end
    end

    // Reflex channels that stay alive pass reflex data in place of commands
    integer k;
    always @* begin
        sel_data = cmd_data_in;
        for (k = 0; k < NCH; k = k + 1) begin
            if (reflex_ch_in[k]) begin
                sel_data[k*`DATA_WIDTH +: `DATA_WIDTH] =
                    reflex_data_in[k*`DATA_WIDTH +: `DATA_WIDTH];
            end
        end
    end

    assign ch_mux_fb = ch_fb_nxt;

    genvar i;
    generate
        for (i = 0; i < NCH; i = i + 1) begin : g_ch
            wire [`DATA_WIDTH-1:0] raw;
            wire [`DATA_WIDTH-1:0] legal;
            assign raw = cfg_value_in[i*`DATA_WIDTH +: `DATA_WIDTH];
            // Out-of-range analog settings are clipped and discrete ones cut to bit 0, so a bad image cannot drive junk
            assign legal = analog_ch_in[i] ?
                ((raw > `ANALOG_MAX) ? `ANALOG_MAX : raw) :
                {{(`DATA_WIDTH-1){1'b0}}, raw[0]};
            assign eff_mode[i] = auto_config_in ? `RST_MODE : cfg_mode_in[i];
            assign eff_value[i*`DATA_WIDTH +: `DATA_WIDTH] =
                auto_config_in ? `RST_VALUE : legal;
            channel_output u_ch (
                .core_clk_in(core_clk_in),
                .rstn_in(rstn_in),
                .ce_in(ce_in),
                .fallback_in(ch_mux_fb[i]),
                .mode_in(eff_mode[i]),
                .value_in(eff_value[i*`DATA_WIDTH +: `DATA_WIDTH]),
                .cmd_in(sel_data[i*`DATA_WIDTH +: `DATA_WIDTH]),
                .out_out(ch_data_out[i*`DATA_WIDTH +: `DATA_WIDTH])
            );
        end
    endgenerate
endmodule // output_fallback_control

// File: tb/island_modules_model.sv
/* Far-side heartbeat sources: one pulse per enabled island module.
   Assumes one clock; pulses land shortly after the edge, like bench stimulus. */
`timescale 1ns/1ps
`include "output_fallback_defines.vh"
module island_modules_model #(
    parameter PERIOD = 8
) (
    input wire core_clk_in,
    input wire rstn_in,
    input wire [`NUM_MODULES-1:0] en_in,
    output reg [`NUM_MODULES-1:0] hb_out
);
    integer cnt_r = 0;
    initial hb_out = {`NUM_MODULES{1'b0}};
    // A module with its enable low goes silent, which is how a dead module looks
    always @(posedge core_clk_in) begin
        cnt_r <= (!rstn_in || cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
        hb_out <= #1 (cnt_r == 0) ? en_in : {`NUM_MODULES{1'b0}};
    end
endmodule // island_modules_model

// File: tb/fallback_checker.sv
/* Port assertions for the output fallback controller.
   Bound to output_fallback_control; one clock, sync active-low reset. */
`timescale 1ns/1ps
`include "output_fallback_defines.vh"
module fallback_checker #(parameter HB_PERIOD = 8, parameter HB_TIMEOUT = 40) (
    input wire core_clk_in, input wire rstn_in, input wire ce_in,
    input wire fieldbus_ok_in, input wire run_cmd_in, input wire recover_in,
    input wire auto_config_in, input wire gateway_hb_out, input wire island_fallback_out,
    input wire [`NUM_MODULES-1:0] module_present_in, module_mandatory_in,
    input wire [`NUM_MODULES-1:0] module_operating_in, module_timeout_out,
    input wire [`NUM_MODULES*`NUM_CHANNELS-1:0] reflex_ch_in, cfg_mode_in,
    input wire [`NUM_MODULES*`NUM_CHANNELS*`DATA_WIDTH-1:0] cfg_value_in, ch_data_out
);
    reg [15:0] gap_r;
    wire mand_bad = |(module_mandatory_in & ~(module_present_in & module_operating_in));
    wire ch0_fb = ce_in & ~fieldbus_ok_in & module_present_in[0] & module_operating_in[0]
        & ~reflex_ch_in[0];
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    // Cleared in fallback, since the first beat after recovery may take a full period
    always @(posedge core_clk_in) begin
        if (!rstn_in || gateway_hb_out || island_fallback_out) begin
            gap_r <= 16'h0000;
        end else if (ce_in) begin
            gap_r <= gap_r + 16'h0001;
        end
    end
    AST_LINK_LOSS: assert property (ce_in && !fieldbus_ok_in |=> island_fallback_out)
        else $error("link loss without fallback");
    AST_STOP_CMD: assert property (ce_in && !run_cmd_in |=> island_fallback_out)
        else $error("stop command without fallback");
    AST_MAND_MISS: assert property (ce_in && mand_bad |=> island_fallback_out)
        else $error("missing mandatory module without fallback");
    AST_TIMEOUT_FB: assert property (|module_timeout_out |-> island_fallback_out)
        else $error("heartbeat timeout without fallback");
    AST_HB_MUTE: assert property (island_fallback_out |-> !gateway_hb_out)
        else $error("gateway heartbeat sent in fallback");
    AST_HB_GAP: assert property (gap_r <= HB_PERIOD)
        else $error("gateway heartbeat late");
    AST_TO_STICKY: assert property (ce_in && !recover_in
        |=> (module_timeout_out & $past(module_timeout_out)) == $past(module_timeout_out))
        else $error("timeout flag dropped without recovery");
    AST_PREDEF: assert property (ch0_fb && !auto_config_in && !cfg_mode_in[0]
        |=> ch_data_out[15:0] == $past(cfg_value_in[15:0])) else $error("wrong fallback value");
    AST_AUTO_ZERO: assert property (ch0_fb && auto_config_in
        |=> ch_data_out[15:0] == `RST_VALUE) else $error("auto-config value not zero");
    COV_FB_ENTER: cover property ($rose(island_fallback_out));
    COV_RECOVER: cover property ($fell(island_fallback_out));
    COV_TIMEOUT: cover property (|module_timeout_out);
endmodule // fallback_checker

bind output_fallback_control fallback_checker #(.HB_PERIOD(HB_PERIOD),
    .HB_TIMEOUT(HB_TIMEOUT)) chk_i (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
    .ce_in(ce_in), .fieldbus_ok_in(fieldbus_ok_in), .run_cmd_in(run_cmd_in),
    .recover_in(recover_in), .auto_config_in(auto_config_in), .gateway_hb_out(gateway_hb_out),
    .island_fallback_out(island_fallback_out), .module_present_in(module_present_in),
    .module_mandatory_in(module_mandatory_in), .module_operating_in(module_operating_in),
    .module_timeout_out(module_timeout_out), .reflex_ch_in(reflex_ch_in),
    .cfg_mode_in(cfg_mode_in), .cfg_value_in(cfg_value_in), .ch_data_out(ch_data_out));

// File: tb/output_fallback_control_tb.sv
/* Scenario bench for output_fallback_control with the far-side heartbeat model.
   Assumes the checker is bound in; short heartbeat counts keep the run brief. */
`timescale 1ns/1ps
`include "output_fallback_defines.vh"
module output_fallback_control_tb;
    localparam HBP = 8;
    localparam HBT = 40;
    localparam DW = `NUM_MODULES*`NUM_CHANNELS*`DATA_WIDTH;
    reg clk = 1'b0, rst_n = 1'b0, link_ok = 1'b1, run = 1'b1, rec = 1'b0, autocfg = 1'b0;
    reg ce = 1'b1;
    reg [3:0] two_ch = 4'h0;
    reg [7:0] analog = 8'h00;
    reg [3:0] pres = 4'hF, mand = 4'h0, oper = 4'hF, hb_en = 4'hF;
    reg [7:0] refl = 8'h00, srcok = 8'hFF;
    reg [DW-1:0] cfg = {DW{1'b0}}, cmd = {8{16'h3C3C}};
    wire gw_hb, fb;
    wire [3:0] hb, to;
    wire [7:0] chfb;
    wire [DW-1:0] data;
    int err_count = 0, cmp_count = 0;
    output_fallback_control #(.HB_PERIOD(HBP), .HB_TIMEOUT(HBT)) dut (
        .core_clk_in(clk), .rstn_in(rst_n), .ce_in(ce), .fieldbus_ok_in(link_ok),
        .run_cmd_in(run), .recover_in(rec), .auto_config_in(autocfg), .module_hb_in(hb),
        .module_present_in(pres), .module_mandatory_in(mand), .module_operating_in(oper),
        .reflex_ch_in(refl), .reflex_src_ok_in(srcok), .analog_ch_in(analog),
        .two_ch_digital_in(two_ch), .cfg_mode_in(8'hAA), .cfg_value_in(cfg),
        .cmd_data_in(cmd), .reflex_data_in({8{16'h0F0F}}), .gateway_hb_out(gw_hb),
        .island_fallback_out(fb), .module_timeout_out(to), .ch_fallback_out(chfb),
        .ch_data_out(data));
    island_modules_model #(.PERIOD(HBP)) far (.core_clk_in(clk), .rstn_in(rst_n),
        .en_in(hb_en), .hb_out(hb));
    initial forever #2 clk = ~clk;
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task chk(input string nm, input logic [DW-1:0] e, input logic [DW-1:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task count_hb(input int c, output int n);
        n = 0;
        repeat (c) begin
            step(1);
            if (gw_hb === 1'b1) n++;
        end
    endtask
    // Held two cycles: a sticky timeout is cleared first and blocks that cycle
    task recov;
        rec = 1'b1;
        step(2);
        rec = 1'b0;
        step(3);
        chk("island_fallback_out", 0, fb);
    endtask
    task t_hbper;
        int n;
        count_hb(4*HBP, n);
        chk("gateway_hb_out count", 4, n);
    endtask
    task t_link;
        int n;
        cfg = {8{16'h0001}};
        refl = 8'h40;
        link_ok = 1'b0;
        step(2);
        cmd = {8{16'h7777}};
        chk("island_fallback_out", 1, fb);
        chk("ch_fallback_out[6]", 1, chfb[6]);
        two_ch = 4'h8;
        refl = 8'hC0;
        step(2);
        chk("ch_fallback_out[7:6]", 0, chfb[7:6]);
        chk("ch_data_out[127:96]", 32'h0F0F0F0F, data[127:96]);
        two_ch = 4'h0;
        refl = 8'h40;
        count_hb(2*HBP, n);
        chk("gateway_hb_out count", 0, n);
        chk("ch_data_out[31:0]", 32'h3C3C0001, data[31:0]);
        cmd = {8{16'h3C3C}};
        link_ok = 1'b1;
        recov;
    endtask
    task t_stop;
        run = 1'b0;
        step(2);
        chk("island_fallback_out", 1, fb);
        rec = 1'b1;
        step(1);
        rec = 1'b0;
        step(3);
        chk("island_fallback_out", 1, fb);
        run = 1'b1;
        recov;
    endtask
    task t_mand;
        for (int k = 0; k < 2; k++) begin
            mand = 4'h2;
            if (k == 0) oper = 4'hD;
            else pres = 4'hD;
            step(2);
            chk("island_fallback_out", 1, fb);
            chk("ch_fallback_out[3:2]", 0, chfb[3:2]);
            mand = 4'h0;
            oper = 4'hF;
            pres = 4'hF;
            recov;
        end
    endtask
    task t_hb;
        hb_en = 4'hB;
        step(HBT + 2*HBP);
        chk("module_timeout_out", 4'h4, to);
        chk("island_fallback_out", 1, fb);
        chk("ch_fallback_out[6]", 0, chfb[6]);
        srcok = 8'hBF;
        step(2);
        chk("ch_fallback_out[6]", 1, chfb[6]);
        srcok = 8'hFF;
        hb_en = 4'hF;
        step(HBP);
        recov;
    endtask
    task t_auto;
        autocfg = 1'b1;
        link_ok = 1'b0;
        step(2);
        chk("ch_data_out[31:0]", 0, data[31:0]);
        autocfg = 1'b0;
        step(2);
        chk("ch_data_out[31:0]", 32'h3C3C0001, data[31:0]);
        analog = 8'h01;
        cfg[15:0] = 16'h1234;
        step(2);
        chk("ch_data_out[15:0]", 16'h1234, data[15:0]);
        analog = 8'h00;
        cfg[15:0] = 16'h0001;
        link_ok = 1'b1;
        recov;
    endtask
    // Clock enable low freezes the trigger path as well
    task t_ce;
        ce = 1'b0;
        link_ok = 1'b0;
        step(3*HBP);
        chk("island_fallback_out", 0, fb);
        ce = 1'b1;
        step(2);
        chk("island_fallback_out", 1, fb);
        link_ok = 1'b1;
        recov;
    endtask
    task test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Generous bound: the scenarios need well under a thousand cycles
    initial begin
        #10000;
        err_count++;
        test_done;
    end
    initial begin
        step(6);
        chk("ch_data_out", 0, data);
        chk("ch_fallback_out", 8'hFF, chfb);
        rst_n = 1'b1;
        recov;
        t_hbper;
        t_link;
        t_stop;
        t_mand;
        t_hb;
        t_auto;
        t_ce;
        test_done;
    end
endmodule // output_fallback_control_tb
